// >>> design/conv_ctrl_pkg.sv
// shared constants for the converter start/readout controller
package conv_ctrl_pkg;
  // ==========================================================
  // timing, expressed in converter clock periods; the capture delay in sys clocks
  localparam int CONV_CLOCKS      = 40;   // clocks per conversion
  localparam int GUARD_CLOCKS     = 4;    // wait after done rises
  localparam int SHIFT_STAGES     = 4;    // start delay stages
  localparam int CNT_PRELOAD      = 11;   // counter load on start
  localparam int CNT_WIDTH        = 4;
  localparam int RATE_DIVISOR     = 44;   // safe rate fclk/44
  localparam int MAX_START_HALF   = 7;    // start pulse limit, half clocks
  localparam int CAPTURE_DELAY    = 7;    // sys clocks from done rise to capture
  // ==========================================================
  // avalon register map (byte addresses)
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS   = 4'h8;
  localparam logic [3:0] COUNT_OFS  = 4'hC;
  // ctrl fields
  localparam int CTRL_START_BIT = 0;   // one-shot request
  localparam int CTRL_RUN_BIT   = 1;   // continuous level request
  localparam int CTRL_MODE_BIT  = 2;   // 0 latch path, 1 counter path
  localparam int CTRL_FREE_BIT  = 3;   // flip-flop free-running mode
  localparam int CTRL_OE_BIT    = 4;   // drive output enable
  localparam int CTRL_INV_BIT   = 5;   // return true binary
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_READY_BIT = 2;
  localparam int STAT_PEND_BIT  = 3;
  localparam int STAT_NEW_BIT   = 4;   // fresh result, cleared on data read
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : conv_ctrl_pkg

// >>> design/pin_sync.sv
// two-flop synchroniser for pins from the converter
`timescale 1ns/10ps
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0  // idle level of each pin
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : pin_sync

// >>> design/conv_ctrl.sv
// host-side controller that starts the converter and collects results
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - free run: done fed back to start
// - explicit start still issued after reset
// - wait four clocks after done rises
// - rate below clock over 44 is safe
// - free run through flop, clear stops it
// - request latched, delayed through four stages
// - latch cleared one clock after done falls
// - counter path converts while request high
// - counter loads eleven on start, holds till done
// - carry four clocks after done, clears request
// - start pulse never beyond three and half clocks
module conv_ctrl #(
  parameter int DATA_W = 8
) (
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // converter pins
  output logic                   conv_clk_o,
  output logic                   start_conv_o,
  output logic                   out_enable_o,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  // host events
  output logic                   ready_o,
  output logic                   result_valid_o
);
  // ==========================================================
  // synchronised converter pins
  logic              done_s;
  logic [DATA_W-1:0] data_s;
  logic              done_prev_q;
  wire               done_rise = done_s & ~done_prev_q;
  wire               done_fall = ~done_s & done_prev_q;

  // done idles high: resetting its stages high avoids a false edge after reset
  pin_sync #(
    .WIDTH     (DATA_W + 1),
    .RESET_VAL ({1'b1, {DATA_W{1'b0}}})
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({conv_done_i, conv_data_i}),
    .sync_o    ({done_s, data_s})
  );

  // ==========================================================
  // register bus decode; writes take no wait state, reads take one
  logic [5:0]        ctrl_q;
  logic [DATA_W-1:0] result_q;
  logic              new_q;
  logic [15:0]       count_q;
  logic              rd_ack_q;
  wire  wr_ctrl  = avs_write_i & (avs_address_i == conv_ctrl_pkg::CTRL_OFS) & avs_byteenable_i[0];
  wire  rd_data  = avs_read_i & rd_ack_q & (avs_address_i == conv_ctrl_pkg::DATA_OFS);
  wire  wr_start = wr_ctrl & avs_writedata_i[conv_ctrl_pkg::CTRL_START_BIT];
  wire  run_lvl  = ctrl_q[conv_ctrl_pkg::CTRL_RUN_BIT];
  wire  mode_cnt = ctrl_q[conv_ctrl_pkg::CTRL_MODE_BIT];
  wire  free_run = ctrl_q[conv_ctrl_pkg::CTRL_FREE_BIT];
  // registered read data need one wait state to stand at the accepting edge
  assign avs_waitrequest_o = avs_read_i & ~rd_ack_q;

  // control register, start bit self-clearing
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= conv_ctrl_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {avs_writedata_i[5:1], 1'b0};
    end
  end

  // ==========================================================
  // converter clock: sys_clk divided by two, output by flop
  logic cclk_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cclk_q <= 1'b0;
    end else begin
      cclk_q <= ~cclk_q;
    end
  end
  assign conv_clk_o = cclk_q;
  // step is the sys edge where the converter clock falls, so every pin the
  // converter samples has settled half a converter clock before its rising edge
  wire step = cclk_q;

  // ==========================================================
  // request latch, set any time, cleared after start issued
  logic       req_q;
  logic [3:0] shift_q;
  logic       start_q;
  logic       clr_pend_q;
  logic [conv_ctrl_pkg::CNT_WIDTH-1:0] cnt_q;
  logic       cnt_run_q;
  logic       carry_q;
  logic       boot_q;
  logic       ff_start_q;
  wire        req_set = wr_start | run_lvl | (boot_q & ~free_run);
  wire        cnt_top = (cnt_q == '1);
  wire        carry   = cnt_run_q & cnt_top & step;
  logic       cnt_busy_q;
  logic [2:0] guard_q;
  // no start leaves before the guard ends, which also keeps the start
  // rate under the clock over 44
  wire        guard_ok = (guard_q == 3'(conv_ctrl_pkg::GUARD_CLOCKS));

  // ==========================================================
  // guard counter restarts whenever the converter shows busy
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      guard_q <= '0;
    end else if (!done_s) begin
      guard_q <= '0;
    end else if (step && !guard_ok) begin
      guard_q <= guard_q + 3'd1;
    end
  end

  // set wins over clear so a request in the clear cycle survives
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_q <= 1'b0;
    end else if (req_set) begin
      req_q <= 1'b1;
    end else if ((!mode_cnt && clr_pend_q && step) || (mode_cnt && carry)) begin
      req_q <= 1'b0;
    end
  end

  // one converter clock after done falls the latch may clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_pend_q <= 1'b0;
    end else if (done_fall) begin
      clr_pend_q <= 1'b1;
    end else if (step) begin
      clr_pend_q <= 1'b0;
    end
  end

  // four-stage delay in converter clocks; the guard interval is kept by guard_ok
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= '0;
    end else if (step) begin
      shift_q <= {shift_q[2:0], req_q & ~start_q & ~shift_q[3]};
    end
  end

  // start pulse exactly one converter clock wide, well under 3.5
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_q <= 1'b0;
    end else if (step) begin
      start_q <= shift_q[3] & done_s & guard_ok & ~start_q & ~(mode_cnt & cnt_run_q);
    end
  end

  // ==========================================================
  // counter path: load 11 on start, hold until done rises
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q     <= '0;
      cnt_run_q <= 1'b0;
    end else if (start_q && step) begin
      cnt_q     <= conv_ctrl_pkg::CNT_WIDTH'(conv_ctrl_pkg::CNT_PRELOAD);
      cnt_run_q <= 1'b1;
    end else if (carry) begin
      cnt_run_q <= 1'b0;
    end else if (cnt_run_q && cnt_busy_q && done_s && !cnt_top && step) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // counting may only begin once the converter has really gone busy; the
  // synchronised done still reads high for a few clocks after the start
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_busy_q <= 1'b0;
    end else if (start_q && step) begin
      cnt_busy_q <= 1'b0;
    end else if (cnt_run_q && !done_s) begin
      cnt_busy_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= carry;
    end
  end
  assign ready_o = carry_q;

  // ==========================================================
  // free-run flop: done into D, clear from the control bit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ff_start_q <= 1'b0;
    end else if (!free_run) begin
      ff_start_q <= 1'b0;
    end else if (step) begin
      ff_start_q <= done_s & guard_ok & ~ff_start_q;
    end
  end

  // one boot start after reset, masked while free-run is set
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_q <= 1'b1;
    end else if (start_q) begin
      boot_q <= 1'b0;
    end
  end

  assign start_conv_o = free_run ? (ff_start_q | start_q) : start_q;
  assign out_enable_o = ctrl_q[conv_ctrl_pkg::CTRL_OE_BIT];

  // ==========================================================
  // result capture a guard interval after done rises
  logic [2:0] cap_cnt_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_cnt_q <= '0;
    end else if (done_rise) begin
      cap_cnt_q <= 3'(conv_ctrl_pkg::CAPTURE_DELAY);  // transfer about 200 ns
    end else if (cap_cnt_q != 3'd0) begin
      cap_cnt_q <= cap_cnt_q - 3'd1;
    end
  end
  wire capture = (cap_cnt_q == 3'd1);

  // converter data arrive complemented; optional inversion
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_q <= '0;
      count_q  <= '0;
    end else if (capture) begin
      result_q <= ctrl_q[conv_ctrl_pkg::CTRL_INV_BIT] ? ~data_s : data_s;
      count_q  <= count_q + 16'h0001;
    end
  end

  // fresh flag: capture beats a read in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      new_q <= 1'b0;
    end else if (capture) begin
      new_q <= 1'b1;
    end else if (rd_data) begin
      new_q <= 1'b0;
    end
  end
  assign result_valid_o = new_q;

  // ==========================================================
  // read mux, registered
  logic [31:0] rd_mux;
  always_comb begin
    unique case (avs_address_i)
      conv_ctrl_pkg::CTRL_OFS:   rd_mux = {26'h000_0000, ctrl_q};
      conv_ctrl_pkg::STATUS_OFS: rd_mux = {27'h000_0000, new_q, req_q,
                                           ~cnt_run_q, done_s, ~done_s};
      conv_ctrl_pkg::DATA_OFS:   rd_mux = {{(32-DATA_W){1'b0}}, result_q};
      conv_ctrl_pkg::COUNT_OFS:  rd_mux = {16'h0000, count_q};
      default:                   rd_mux = conv_ctrl_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_prev_q    <= 1'b1;
      avs_readdata_o <= '0;
      rd_ack_q       <= 1'b0;
    end else begin
      done_prev_q    <= done_s;
      avs_readdata_o <= avs_read_i ? rd_mux : 32'h0000_0000;
      rd_ack_q       <= avs_read_i & ~rd_ack_q;
    end
  end
endmodule : conv_ctrl

// >>> bench/conv_ctrl_monitor.sv
// assertion checker for the converter start/readout controller
`timescale 1ns/10ps
module conv_ctrl_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic              sys_clk_i,
  input wire logic              nrst_i,
  input wire logic [3:0]        avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              conv_clk_o,
  input wire logic              start_conv_o,
  input wire logic              out_enable_o,
  input wire logic              conv_done_i,
  input wire logic [DATA_W-1:0] conv_data_i,
  input wire logic              ready_o,
  input wire logic              result_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // start pin and converter clock
  sequence s_pulse;
    start_conv_o [*2] ##1 !start_conv_o;
  endsequence
  property p_width; $rose(start_conv_o) |-> s_pulse; endproperty
  a_width: assert property (p_width) else $error("start pulse width wrong");
  property p_guard; $rose(conv_done_i) |-> !start_conv_o [*8]; endproperty
  a_guard: assert property (p_guard) else $error("start inside guard");
  property p_idle; $rose(start_conv_o) |-> conv_done_i; endproperty
  a_idle: assert property (p_idle) else $error("start while busy");
  property p_toggle; $past(nrst_i) |-> conv_clk_o != $past(conv_clk_o); endproperty
  a_toggle: assert property (p_toggle) else $error("converter clock stuck");
  // ==========================================
  // carry, result and bus side
  property p_ready; ready_o |=> !ready_o; endproperty
  a_ready: assert property (p_ready) else $error("carry too long");
  property p_carry; ready_o |-> conv_done_i && $past(conv_done_i, 4); endproperty
  a_carry: assert property (p_carry) else $error("carry too early");
  property p_valid; $rose(result_valid_o) |-> conv_done_i; endproperty
  a_valid: assert property (p_valid) else $error("result before done");
  property p_oe;
    !(avs_write_i && avs_address_i == 4'h0) [*2] |=> $stable(out_enable_o);
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved unasked");
  property p_noread; !avs_read_i |=> avs_readdata_o == 32'h0000_0000; endproperty
  a_noread: assert property (p_noread) else $error("read data not idle");
endmodule : conv_ctrl_monitor

// >>> bench/conv_model.sv
// behavioural model of the converter on the far side
`timescale 1ns/10ps
module conv_model (
  input  wire logic       conv_clk_i,
  input  wire logic       start_i,
  input  wire logic       oe_i,
  input  wire logic [7:0] level_i,
  output logic            done_o,
  output logic [7:0]      data_o
);
  logic [7:0] latch_q, sar_q, trial;
  logic [5:0] cnt_q;
  logic [2:0] guard_q;
  initial begin
    done_o = 1'b1;
    latch_q = 8'h00;
    sar_q = 8'h00;
    cnt_q = 6'h00;
    guard_q = 3'h0;
  end
  // midpoint first, then halving steps
  assign trial = 8'h80 >> (cnt_q - 6'h01);
  // no pull on the bus: a disabled output shows the latch inverted
  assign data_o = oe_i ? latch_q : ~latch_q;
  // search, busy level and result latch
  always @(posedge conv_clk_i) begin
    if (guard_q != 3'h0)
      guard_q <= guard_q - 3'h1; // starts inside the guard after done are dropped
    if (start_i && guard_q == 3'h0) begin
      cnt_q <= 6'h01;
      done_o <= 1'b0;
      sar_q <= 8'h00;
    end else if (cnt_q != 6'h00 && cnt_q < 6'd40) begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q <= 6'h08 && level_i >= (sar_q | trial))
        sar_q <= sar_q | trial;
    end else if (cnt_q == 6'd40) begin
      latch_q <= ~sar_q;
      done_o <= 1'b1;
      cnt_q <= 6'h00;
      guard_q <= 3'h4;
    end
  end
endmodule : conv_model

// >>> bench/conv_ctrl_tb.sv
// self-checking bench for the converter start/readout controller
`timescale 1ns/10ps
module conv_ctrl_tb;
  logic        sys_clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        conv_clk_o, start_conv_o, out_enable_o, conv_done_i, ready_o, result_valid_o;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d, c0;
  logic [7:0]  conv_data_i, level_q;
  logic [7:0]  lv [4] = '{8'h01, 8'hFF, 8'h5A, 8'hA5};
  int          n_mismatch = 0, tests_run = 0, cycles = 0, n_ready = 0, r0;
  conv_ctrl #(.DATA_W(8)) u_conv_ctrl (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .conv_clk_o(conv_clk_o), .start_conv_o(start_conv_o), .out_enable_o(out_enable_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .ready_o(ready_o),
    .result_valid_o(result_valid_o));
  conv_model u_conv_model (.conv_clk_i(conv_clk_o), .start_i(start_conv_o),
    .oe_i(out_enable_o), .level_i(level_q), .done_o(conv_done_i), .data_o(conv_data_i));
  // ==========================================
  // clock, hang guard and carry counter
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (ready_o === 1'b1)
      n_ready++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================
  // bus tasks: hold the request until waitrequest is sampled low
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    v = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask : rd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : check
  task automatic wait_valid;
    for (int n = 0; n < 400 && result_valid_o !== 1'b1; n++)
      @(posedge sys_clk_i);
    check({31'h0, result_valid_o}, 32'h0000_0001);
  endtask : wait_valid
  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // ==========================================
  // main sequence
  initial begin
    nrst_i = 1'b0;
    level_q = 8'h00;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hF;
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    wr(4'h0, 32'h0000_0010);
    wait_valid();
    rd(4'h8, d);
    check(d, 32'h0000_00FF);
    rd(4'hC, c0);
    for (int i = 0; i < 4; i++) begin
      level_q <= lv[i];
      wr(4'h0, {26'h0, i[0], 5'h11});
      wait_valid();
      rd(4'h8, d);
      check(d, {24'h0, i[0] ? lv[i] : ~lv[i]});
      rd(4'h4, d);
      check({29'h0, d[4], d[1], d[0]}, 32'h0000_0002);
    end
    rd(4'hC, d);
    check(d, c0 + 32'h0000_0004);
    // continuous level request on the counter path
    r0 = n_ready;
    wr(4'h0, 32'h0000_0016);
    repeat (400) @(posedge sys_clk_i);
    wr(4'h0, 32'h0000_0010);
    check({31'h0, n_ready - r0 >= 2}, 32'h0000_0001);
    // flop free run, then stopped by its clear
    rd(4'hC, c0);
    wr(4'h0, 32'h0000_0018);
    repeat (400) @(posedge sys_clk_i);
    wr(4'h0, 32'h0000_0010);
    repeat (200) @(posedge sys_clk_i);
    rd(4'hC, d);
    check({31'h0, d - c0 >= 3}, 32'h0000_0001);
    repeat (200) @(posedge sys_clk_i);
    rd(4'hC, c0);
    check(c0, d);
    rd(4'h2, d);
    check(d, 32'h0000_0000);
    stop_test();
  end
endmodule : conv_ctrl_tb
bind conv_ctrl conv_ctrl_monitor #(.DATA_W(DATA_W)) u_conv_ctrl_monitor (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .conv_clk_o(conv_clk_o),
  .start_conv_o(start_conv_o), .out_enable_o(out_enable_o), .conv_done_i(conv_done_i),
  .conv_data_i(conv_data_i), .ready_o(ready_o), .result_valid_o(result_valid_o));
